// [include/rst_pwr_pkg.sv]
// Constants, register map and helpers of the reset and power controller
package rst_pwr_pkg;
  // Clock and time base
  localparam int CLK_HZ = 10000000;
  localparam int WARMUP_MS = 40;
  localparam int WARMUP_CYCLES = WARMUP_MS * (CLK_HZ / 1000);
  localparam int WARM_CNT_W = 20;
  localparam int SRC_HZ = 24000;
  localparam int WDT_LONG_MS = 360;
  localparam int WDT_BASE_TICKS = WDT_LONG_MS * SRC_HZ / 1000;
  localparam int WDT_CNT_W = 16;
  localparam logic [1:0] PIN_MIN_TICKS = 2'h2;
  localparam logic [WARM_CNT_W-1:0] RST_HOLD_CYCLES = 20'h00004;

  // Special-function register addresses and the software reset key
  localparam logic [7:0] ADDR_OPTION = 8'h94;
  localparam logic [7:0] ADDR_INTFLAG = 8'h95;
  localparam logic [7:0] ADDR_SOFTWARE_COMMAND = 8'h97;
  localparam logic [7:0] ADDR_WDTCTL = 8'hF7;
  localparam logic [7:0] ADDR_AUX = 8'hF8;
  localparam logic [7:0] SW_RESET_KEY = 8'h56;

  // Flash locations of the configuration word
  localparam logic [12:0] CFG_LOW_ADDR = 13'h1FFE;
  localparam logic [12:0] CFG_HIGH_ADDR = 13'h1FFF;

  // Field positions
  localparam int OPT_DIRECT_BIT = 6;
  localparam int OPT_WPSEL_LSB = 4;
  localparam int FLAG_LVD_BIT = 7;
  localparam int AUX_WATCHDOG_CLEAR_BIT_BIT = 7;
  localparam int CFGL_WMODE_LSB = 6;
  localparam int CFGH_PIN_EN_BIT = 6;
  localparam int CFGH_LOW_VOLTAGE_RESET_SELECT_LSB = 4;
  localparam int CFGH_NOISE_BIT = 3;
  localparam int CFGH_SAVE_BIT = 2;

  // Reset values
  localparam logic [7:0] OPTION_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;

  // Low-voltage reset select codes
  localparam logic [1:0] LVR_HIGH = 2'h0;
  localparam logic [1:0] LVR_MID = 2'h1;
  localparam logic [1:0] LVR_OFF = 2'h2;
  localparam logic [1:0] LVR_LOW = 2'h3;

  typedef enum logic [4:0] {
    ST_WARMUP = 5'h01,
    ST_LOAD_LO = 5'h02,
    ST_LOAD_HI = 5'h04,
    ST_LOAD_END = 5'h08,
    ST_RUN = 5'h10
  } ctl_state_t;

  // Overflow limit in slow RC ticks: each step of the select halves the period
  function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [WDT_CNT_W-1:0] base,
                                                    input logic [1:0] psel);
    wdt_limit = base >> psel;
  endfunction
endpackage

// [include/wdt_link_if.sv]
// Signals between the controller and its watchdog counter
`timescale 1ns/1ps
interface wdt_link_if;
  logic tick;
  logic clr;
  logic run;
  logic [1:0] psel;
  logic ovf;
  modport ctrl (output tick, output clr, output run, output psel, input ovf);
  modport wdt (input tick, input clr, input run, input psel, output ovf);
endinterface

// [core/watchdog_timer.sv]
// Watchdog counter on the slow RC time base
`timescale 1ns/1ps
module watchdog_timer
  import rst_pwr_pkg::*;
#(
  parameter logic [rst_pwr_pkg::WDT_CNT_W-1:0] BASE_TICKS = 16'h21C0
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  wdt_link_if.wdt lnk
);
  typedef struct packed {
    logic [WDT_CNT_W-1:0] cnt;
    logic ovf;
  } wdt_state_t;

  wdt_state_t cur_ff;
  wdt_state_t nxt_ff;
  logic [WDT_CNT_W-1:0] limit;

  assign lnk.ovf = cur_ff.ovf;

  always_comb
  begin
    limit = wdt_limit(BASE_TICKS, lnk.psel);
    nxt_ff = cur_ff;
    nxt_ff.ovf = 1'b0;
    if (lnk.clr)
    begin
      nxt_ff.cnt = '0;
    end
    else if (lnk.tick && lnk.run)
    begin
      // A shortened period below the count still overflows at once
      if (cur_ff.cnt >= limit - 16'h0001)
      begin
        nxt_ff.cnt = '0;
        nxt_ff.ovf = 1'b1;
      end
      else
      begin
        nxt_ff.cnt = cur_ff.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_ff <= '0;
    end
    else if (ce)
    begin
      cur_ff <= nxt_ff;
    end
  end
endmodule

// [core/reset_power_watchdog_ctrl.sv]
// Reset sources, warm-up, configuration load, regulator and watchdog control
`timescale 1ns/1ps
// Contract
// - Five reset sources; SFRs return to defaults
// - Power-on: 40 ms warm-up, then load config
// - Other resets keep loaded configuration
// - Pin reset low for two slow ticks
// - Pin reset only when enable bit set
// - Writing 56h to 97h resets chip
// - Watchdog counts slow RC ticks
// - Watchdog reset enable held at F7h
// - Mode field: off, run-only, always
// - Period select gives 360/180/90/45 ms
// - Watchdog cleared by reset or clear bit
// - Clear bit self-clears next cycle
// - Low-voltage select field picks reset level
// - Detect flag only with lowest reset level or reset off
// - Detect flag set by hardware, gated off
// - Direct-supply bit turns regulator off
// - Power saving turns regulator off in stop
// - Power saving forces lowest reset level in stop or on direct supply, unless reset off
// - Low config byte bits 7:6 copied to F7h mode field
module reset_power_watchdog_ctrl
#(
  parameter int WARMUP = rst_pwr_pkg::WARMUP_CYCLES,
  parameter logic [rst_pwr_pkg::WDT_CNT_W-1:0] WDT_BASE = 16'(rst_pwr_pkg::WDT_BASE_TICKS)
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin_reset_n,
  input wire logic src_tick,
  input wire logic idle_mode,
  input wire logic stop_mode,
  input wire logic lv_under_high,
  input wire logic lv_under_mid,
  input wire logic lv_under_low,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic flash_rd,
  output logic [12:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  output logic sys_reset_n,
  output logic regulator_enable,
  output logic [1:0] lvr_select,
  output logic lvr_active,
  output logic lvd_active,
  output logic supply_noise_filter,
  output logic cfg_valid
);
  import rst_pwr_pkg::*;

  typedef struct packed {
    ctl_state_t st;
    logic [WARM_CNT_W-1:0] cnt;
    logic [7:0] cfg_lo;
    logic [7:0] cfg_hi;
    logic [7:0] option;
    logic [1:0] wdt_mode;
    logic clr_wdt;
    logic [1:0] pin_cnt;
    logic sys_rst_n;
    logic reg_en;
    logic [1:0] lvr_sel;
    logic lvr_on;
    logic lvd_on;
    logic lvd_flag;
    logic [7:0] rdata;
    logic flash_rd;
    logic [12:0] flash_addr;
    logic cfg_valid;
  } ctl_reg_t;

  ctl_reg_t cur_ff;
  ctl_reg_t nxt_ff;
  wdt_link_if wlink();

  logic direct;
  logic save;
  logic pin_en;
  logic [1:0] low_voltage_reset_select;
  logic [1:0] eff_lvr;
  logic low_power;
  logic pin_req;
  logic sw_req;
  logic wdt_req;
  logic lv_req;
  logic any_req;
  logic wr_ok;

  watchdog_timer #(
    .BASE_TICKS(WDT_BASE)
  ) u_wdt (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .lnk(wlink)
  );

  // Decoded configuration and mode terms
  always_comb
  begin
    direct = cur_ff.option[OPT_DIRECT_BIT];
    save = cur_ff.cfg_hi[CFGH_SAVE_BIT];
    pin_en = cur_ff.cfg_hi[CFGH_PIN_EN_BIT];
    low_voltage_reset_select = cur_ff.cfg_hi[CFGH_LOW_VOLTAGE_RESET_SELECT_LSB +: 2];
    low_power = idle_mode | stop_mode;
    eff_lvr = low_voltage_reset_select;
    // Override holds in stop, and in every mode once direct supply is on
    if (save && (stop_mode || direct) && low_voltage_reset_select != LVR_OFF)
    begin
      eff_lvr = LVR_LOW;
    end
    case (eff_lvr)
      LVR_HIGH: lv_req = lv_under_high;
      LVR_MID: lv_req = lv_under_mid;
      LVR_LOW: lv_req = lv_under_low;
      default: lv_req = 1'b0;
    endcase
    // Pin reset needs the enable and a low level seen for two slow ticks
    pin_req = pin_en && cur_ff.pin_cnt == PIN_MIN_TICKS;
    wr_ok = sfr_wr && cur_ff.sys_rst_n;
    sw_req = wr_ok && sfr_addr == ADDR_SOFTWARE_COMMAND && sfr_wdata == SW_RESET_KEY;
    // Mode 10 ignores overflow in idle and stop; 11 always resets
    wdt_req = wlink.ovf && cur_ff.wdt_mode[1]
      && (cur_ff.wdt_mode[0] || !low_power);
    any_req = pin_req || sw_req || wdt_req || lv_req;
  end

  // Watchdog steering
  always_comb
  begin
    wlink.tick = src_tick;
    wlink.clr = cur_ff.clr_wdt || !cur_ff.sys_rst_n;
    // Counter stops in idle and stop unless its reset is always enabled
    wlink.run = !low_power || cur_ff.wdt_mode == 2'h3;
    wlink.psel = cur_ff.option[OPT_WPSEL_LSB +: 2];
  end

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.flash_rd = 1'b0;
    nxt_ff.clr_wdt = 1'b0;

    // Pin filter on slow RC ticks, saturating at the minimum width
    if (pin_reset_n)
    begin
      nxt_ff.pin_cnt = 2'h0;
    end
    else if (src_tick && cur_ff.pin_cnt != PIN_MIN_TICKS)
    begin
      nxt_ff.pin_cnt = cur_ff.pin_cnt + 2'h1;
    end

    case (cur_ff.st)
      ST_WARMUP:
      begin
        if (cur_ff.cnt == WARM_CNT_W'(WARMUP - 1))
        begin
          nxt_ff.cnt = '0;
          nxt_ff.st = ST_LOAD_LO;
          nxt_ff.flash_rd = 1'b1;
          nxt_ff.flash_addr = CFG_LOW_ADDR;
        end
        else
        begin
          nxt_ff.cnt = cur_ff.cnt + 20'h00001;
        end
      end
      ST_LOAD_LO:
      begin
        nxt_ff.st = ST_LOAD_HI;
        nxt_ff.flash_rd = 1'b1;
        nxt_ff.flash_addr = CFG_HIGH_ADDR;
      end
      ST_LOAD_HI:
      begin
        nxt_ff.cfg_lo = flash_rdata;
        nxt_ff.st = ST_LOAD_END;
      end
      ST_LOAD_END:
      begin
        nxt_ff.cfg_hi = flash_rdata;
        nxt_ff.cfg_valid = 1'b1;
        nxt_ff.st = ST_RUN;
        nxt_ff.cnt = RST_HOLD_CYCLES;
      end
      ST_RUN:
      begin
        // Config bytes are never touched here, so they survive
        if (any_req)
        begin
          nxt_ff.sys_rst_n = 1'b0;
          nxt_ff.cnt = RST_HOLD_CYCLES;
        end
        else if (!cur_ff.sys_rst_n)
        begin
          if (cur_ff.cnt == '0)
          begin
            nxt_ff.sys_rst_n = 1'b1;
          end
          else
          begin
            nxt_ff.cnt = cur_ff.cnt - 20'h00001;
          end
        end
      end
      default:
      begin
        nxt_ff.st = ST_WARMUP;
        nxt_ff.cnt = '0;
      end
    endcase

    // Registers held at defaults while the system reset stands
    if (!nxt_ff.sys_rst_n)
    begin
      nxt_ff.option = OPTION_RST;
      nxt_ff.wdt_mode = nxt_ff.cfg_lo[CFGL_WMODE_LSB +: 2];
      nxt_ff.clr_wdt = 1'b0;
    end
    else if (wr_ok)
    begin
      case (sfr_addr)
        ADDR_OPTION: nxt_ff.option = sfr_wdata;
        ADDR_WDTCTL: nxt_ff.wdt_mode = sfr_wdata[CFGL_WMODE_LSB +: 2];
        ADDR_AUX: nxt_ff.clr_wdt = sfr_wdata[AUX_WATCHDOG_CLEAR_BIT_BIT];
        default: nxt_ff.clr_wdt = 1'b0;
      endcase
    end

    // Power outputs follow the live configuration
    nxt_ff.reg_en = !direct && !(stop_mode && save);
    if (!cur_ff.cfg_valid)
    begin
      nxt_ff.reg_en = 1'b1;
    end
    nxt_ff.lvr_sel = eff_lvr;
    nxt_ff.lvr_on = eff_lvr != LVR_OFF;
    // Detect only runs with the lowest reset level or with reset off, which leave it room
    nxt_ff.lvd_on = low_voltage_reset_select[1] && !stop_mode && !(direct && save);
    nxt_ff.lvd_flag = nxt_ff.lvd_on && lv_under_mid;
    if (!cur_ff.cfg_valid)
    begin
      nxt_ff.lvd_flag = 1'b0;
    end

    // Read data is registered and valid the cycle after the strobe
    if (sfr_rd)
    begin
      case (sfr_addr)
        ADDR_OPTION: nxt_ff.rdata = cur_ff.option;
        ADDR_INTFLAG: nxt_ff.rdata = {cur_ff.lvd_flag, 7'h00};
        ADDR_WDTCTL: nxt_ff.rdata = {cur_ff.wdt_mode, 6'h00};
        ADDR_AUX: nxt_ff.rdata = {cur_ff.clr_wdt, 7'h00};
        default: nxt_ff.rdata = 8'h00;
      endcase
    end
  end

  // Stop-mode regulator cut only applies with the regulator otherwise on
  // (direct supply already has it off), which the term above covers

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_ff.st <= ST_WARMUP;
      cur_ff.cnt <= '0;
      cur_ff.cfg_lo <= CFG_RST;
      cur_ff.cfg_hi <= CFG_RST;
      cur_ff.option <= OPTION_RST;
      cur_ff.wdt_mode <= 2'h0;
      cur_ff.clr_wdt <= 1'b0;
      cur_ff.pin_cnt <= 2'h0;
      cur_ff.sys_rst_n <= 1'b0;
      cur_ff.reg_en <= 1'b1;
      cur_ff.lvr_sel <= LVR_HIGH;
      cur_ff.lvr_on <= 1'b1;
      cur_ff.lvd_on <= 1'b0;
      cur_ff.lvd_flag <= 1'b0;
      cur_ff.rdata <= 8'h00;
      cur_ff.flash_rd <= 1'b0;
      cur_ff.flash_addr <= 13'h0000;
      cur_ff.cfg_valid <= 1'b0;
    end
    else if (ce)
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign sfr_rdata = cur_ff.rdata;
  assign flash_rd = cur_ff.flash_rd;
  assign flash_addr = cur_ff.flash_addr;
  assign sys_reset_n = cur_ff.sys_rst_n;
  assign regulator_enable = cur_ff.reg_en;
  assign lvr_select = cur_ff.lvr_sel;
  assign lvr_active = cur_ff.lvr_on;
  assign lvd_active = cur_ff.lvd_on;
  assign supply_noise_filter = cur_ff.cfg_hi[CFGH_NOISE_BIT];
  assign cfg_valid = cur_ff.cfg_valid;
endmodule

// [verification/cfg_flash_model.sv]
// Flash model holding the two configuration bytes
`timescale 1ns/1ps
module cfg_flash_model
  import rst_pwr_pkg::*;
(
  input wire logic mclk,
  input wire logic flash_rd,
  input wire logic [12:0] flash_addr,
  input wire logic [7:0] cfg_lo,
  input wire logic [7:0] cfg_hi,
  output logic [7:0] flash_rdata,
  output int reads
);
  initial flash_rdata = 8'h00;
  initial reads = 0;
  // Data valid one cycle after a read only; toggles otherwise so stale bytes show
  always @(posedge mclk)
  begin
    if (flash_rd)
    begin
      flash_rdata <= (flash_addr == CFG_HIGH_ADDR) ? cfg_hi : cfg_lo;
      reads <= reads + 1;
    end
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule

// [verification/rpw_sva.sv]
// Port checks of the reset and power controller
`timescale 1ns/1ps
module rpw_sva
  import rst_pwr_pkg::*;
#(
  parameter int WARMUP = 20,
  parameter logic [15:0] WDT_BASE = 16'h0010
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic flash_rd,
  input wire logic [12:0] flash_addr,
  input wire logic sys_reset_n,
  input wire logic regulator_enable,
  input wire logic [1:0] lvr_select,
  input wire logic lvr_active,
  input wire logic lvd_active,
  input wire logic cfg_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_lo_read;
    flash_rd && flash_addr == CFG_LOW_ADDR;
  endsequence
  sequence s_hi_read;
    flash_rd && flash_addr == CFG_HIGH_ADDR;
  endsequence
  sequence s_opt_wr;
    ce && sfr_wr && sys_reset_n && sfr_addr == ADDR_OPTION;
  endsequence
  a_cfg_load_order: assert property (s_lo_read |=> s_hi_read) else $error("high byte not read next");
  a_cfg_load_once: assert property (cfg_valid |-> !flash_rd) else $error("flash read after load");
  a_run_needs_cfg: assert property (sys_reset_n |-> cfg_valid) else $error("running before load");
  a_load_then_run: assert property ($rose(cfg_valid) |-> !sys_reset_n ##[1:8] sys_reset_n)
    else $error("release after load late");
  a_sw_key_reset: assert property (ce && sfr_wr && sys_reset_n && sfr_addr == ADDR_SOFTWARE_COMMAND
    && sfr_wdata == SW_RESET_KEY |=> !sys_reset_n) else $error("key write no reset");
  a_reset_min_hold: assert property ($fell(sys_reset_n) |-> !sys_reset_n [*5]) else $error("reset too short");
  a_lvr_code_flag: assert property (lvr_active == (lvr_select != LVR_OFF)) else $error("lvr flag mismatch");
  a_lvd_low_level: assert property (lvd_active |-> lvr_select[1]) else $error("detect with high level");
  a_direct_ldo_off: assert property (s_opt_wr and sfr_wdata[OPT_DIRECT_BIT] |-> ##[1:3] !regulator_enable)
    else $error("regulator still on");
endmodule
bind reset_power_watchdog_ctrl rpw_sva #(.WARMUP(WARMUP), .WDT_BASE(WDT_BASE)) u_sva (.mclk, .rstn, .ce,
  .sfr_addr, .sfr_wr, .sfr_wdata, .flash_rd, .flash_addr, .sys_reset_n, .regulator_enable, .lvr_select,
  .lvr_active, .lvd_active, .cfg_valid);

// [verification/reset_power_watchdog_ctrl_tb.sv]
// Self-checking bench of the reset and power controller
`timescale 1ns/1ps
module reset_power_watchdog_ctrl_tb;
  import rst_pwr_pkg::*;
  logic mclk, rstn, ce, pin_reset_n, src_tick, idle_mode, stop_mode, lv_under_high, lv_under_mid, lv_under_low;
  logic sfr_wr, sfr_rd, flash_rd, sys_reset_n, regulator_enable, lvr_active, lvd_active, supply_noise_filter;
  logic cfg_valid;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_rdata, cfg_lo, cfg_hi, rd;
  logic [12:0] flash_addr;
  logic [1:0] lvr_select;
  int miscompares, num_checks, reads, falls;
  reset_power_watchdog_ctrl #(.WARMUP(20), .WDT_BASE(16'h0010)) DUT (.mclk, .rstn, .ce, .pin_reset_n,
    .src_tick, .idle_mode, .stop_mode, .lv_under_high, .lv_under_mid, .lv_under_low, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .flash_rd, .flash_addr, .flash_rdata, .sys_reset_n, .regulator_enable,
    .lvr_select, .lvr_active, .lvd_active, .supply_noise_filter, .cfg_valid);
  cfg_flash_model flash (.mclk, .flash_rd, .flash_addr, .cfg_lo, .cfg_hi, .flash_rdata, .reads);
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(negedge sys_reset_n) falls++;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(negedge mclk);
    rd = sfr_rdata;
  endtask
  task automatic tick();
    @(posedge mclk);
    src_tick <= 1'b1;
    @(posedge mclk);
    src_tick <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wait_up();
    int n;
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    check("released", {7'h00, sys_reset_n}, 8'h01);
  endtask
  task automatic power_on(input logic [7:0] lo, input logic [7:0] hi);
    int r0;
    r0 = reads;
    cfg_lo = lo;
    cfg_hi = hi;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    wait_up();
    check("flash reads", 8'(reads - r0), 8'h02);
    rdr(ADDR_OPTION);
    check("option", rd, OPTION_RST);
    rdr(ADDR_WDTCTL);
    check("wdt mode", {rd[7:6], 6'h00}, {lo[7:6], 6'h00});
    rdr(8'h80);
    check("unmapped", rd, 8'h00);
    check("lvr code", {6'h00, lvr_select}, {6'h00, hi[5:4]});
    check("noise", {7'h00, supply_noise_filter}, {7'h00, hi[CFGH_NOISE_BIT]});
  endtask
  task automatic t_power();
    int f0;
    f0 = falls;
    wr(ADDR_OPTION, 8'h40);
    rdr(ADDR_OPTION);
    check("option rw", rd, 8'h40);
    check("ldo direct", {7'h00, regulator_enable}, 8'h00);
    check("lvr forced", {6'h00, lvr_select}, {6'h00, LVR_LOW});
    wr(ADDR_OPTION, 8'h00);
    stop_mode <= 1'b1;
    repeat (3) @(negedge mclk);
    check("ldo stop", {7'h00, regulator_enable}, 8'h00);
    check("lvr stop", {6'h00, lvr_select}, {6'h00, LVR_LOW});
    stop_mode <= 1'b0;
    lv_under_mid <= 1'b1;
    rdr(ADDR_INTFLAG);
    check("ldo on", {7'h00, regulator_enable}, 8'h01);
    check("lvd hidden", {7'h00, rd[FLAG_LVD_BIT]}, 8'h00);
    lv_under_mid <= 1'b0;
    // Code 01 resets below the mid level, so the chip must come back up first
    wait_up();
    check("lvr mid", 8'(falls - f0), 8'h01);
  endtask
  task automatic t_resets();
    int f0, r0;
    f0 = falls;
    r0 = reads;
    wr(ADDR_SOFTWARE_COMMAND, 8'h55);
    wr(ADDR_OPTION, 8'h30);
    wr(ADDR_SOFTWARE_COMMAND, SW_RESET_KEY);
    @(negedge mclk);
    check("sw reset", 8'(falls - f0), 8'h01);
    wait_up();
    rdr(ADDR_OPTION);
    check("option default", rd, 8'h00);
    check("no reload", 8'(reads - r0), 8'h00);
    pin_reset_n <= 1'b0;
    tick();
    check("short pin", 8'(falls - f0), 8'h01);
    tick();
    check("pin reset", 8'(falls - f0), 8'h02);
    pin_reset_n <= 1'b1;
    wait_up();
  endtask
  task automatic t_wdt();
    logic [2:0] tbl [4];
    int f0, n;
    logic e;
    tbl = '{3'b000, 3'b100, 3'b101, 3'b111};
    for (int p = 0; p < 4; p++)
    begin
      wr(ADDR_WDTCTL, 8'hC0);
      wr(ADDR_OPTION, {2'b00, 2'(p), 4'h0});
      wr(ADDR_AUX, 8'h80);
      rdr(ADDR_AUX);
      check("clear bit", {rd[7], 7'h00}, 8'h00);
      f0 = falls;
      n = 0;
      while (falls == f0 && n < 40)
      begin
        tick();
        n++;
        if (p == 3 && n == 1)
          wr(ADDR_AUX, 8'h80);
        if (p == 3 && n == 2)
          check("cleared", 8'(falls - f0), 8'h00);
      end
      check("wdt ticks", 8'(n), 8'(16 >> p) + ((p == 3) ? 8'h01 : 8'h00));
      wait_up();
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_WDTCTL, {tbl[i][2:1], 6'h00});
      wr(ADDR_OPTION, 8'h30);
      wr(ADDR_AUX, 8'h80);
      idle_mode <= tbl[i][0];
      f0 = falls;
      repeat (6) tick();
      e = tbl[i][2] && (tbl[i][1] || !tbl[i][0]);
      check("wdt mode", 8'(falls - f0), {7'h00, e});
      idle_mode <= 1'b0;
      wait_up();
    end
  endtask
  task automatic t_second();
    int f0;
    power_on(8'h00, 8'h30);
    f0 = falls;
    pin_reset_n <= 1'b0;
    repeat (4) tick();
    pin_reset_n <= 1'b1;
    check("pin ignored", 8'(falls - f0), 8'h00);
    lv_under_mid <= 1'b1;
    rdr(ADDR_INTFLAG);
    check("lvd flag", {7'h00, rd[FLAG_LVD_BIT]}, 8'h01);
    stop_mode <= 1'b1;
    rdr(ADDR_INTFLAG);
    check("lvd stop", {7'h00, rd[FLAG_LVD_BIT]}, 8'h00);
    stop_mode <= 1'b0;
    lv_under_mid <= 1'b0;
    lv_under_low <= 1'b1;
    repeat (3) @(negedge mclk);
    check("lvr reset", 8'(falls - f0), 8'h01);
    lv_under_low <= 1'b0;
    wait_up();
  endtask
  initial
  begin
    {rstn, sfr_wr, sfr_rd, src_tick, idle_mode, stop_mode, lv_under_high, lv_under_mid, lv_under_low} = '0;
    {ce, pin_reset_n} = 2'b11;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    power_on(8'hC0, 8'h5C);
    t_power();
    t_resets();
    t_wdt();
    t_second();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    conclude();
  end
endmodule
